// *** shared/tws_pkg.sv ***
package tws_pkg;

	// register byte offsets
	localparam logic [11:0] OFF_TASK_STOP = 12'h014;
	localparam logic [11:0] OFF_TASK_SUSPEND = 12'h01C;
	localparam logic [11:0] OFF_TASK_RESUME = 12'h020;
	localparam logic [11:0] OFF_TASK_PREP_RX = 12'h030;
	localparam logic [11:0] OFF_TASK_PREP_TX = 12'h034;
	localparam logic [11:0] OFF_EV_STOPPED = 12'h104;
	localparam logic [11:0] OFF_EV_ERROR = 12'h124;
	localparam logic [11:0] OFF_EV_RX_BEGUN = 12'h14C;
	localparam logic [11:0] OFF_EV_TX_BEGUN = 12'h150;
	localparam logic [11:0] OFF_EV_WRITE = 12'h164;
	localparam logic [11:0] OFF_EV_READ = 12'h168;
	localparam logic [11:0] OFF_SHORTS = 12'h200;
	localparam logic [11:0] OFF_ERR_SRC = 12'h4D0;
	localparam logic [11:0] OFF_MATCH = 12'h4D4;
	localparam logic [11:0] OFF_ENABLE = 12'h500;
	localparam logic [11:0] OFF_RX_PTR = 12'h534;
	localparam logic [11:0] OFF_RX_MAX = 12'h538;
	localparam logic [11:0] OFF_RX_TALLY = 12'h53C;
	localparam logic [11:0] OFF_TX_PTR = 12'h544;
	localparam logic [11:0] OFF_TX_MAX = 12'h548;
	localparam logic [11:0] OFF_TX_TALLY = 12'h54C;
	localparam logic [11:0] OFF_ADDR0 = 12'h588;
	localparam logic [11:0] OFF_ADDR1 = 12'h58C;
	localparam logic [11:0] OFF_CONFIG = 12'h594;
	localparam logic [11:0] OFF_OVERREAD = 12'h5C0;
	localparam logic [11:0] RAM_BASE = 12'h800;
	localparam logic [11:0] RAM_END = 12'h900;

	// event bit positions
	localparam int EV_STOPPED = 0;
	localparam int EV_ERROR = 1;
	localparam int EV_RX_BEGUN = 2;
	localparam int EV_TX_BEGUN = 3;
	localparam int EV_WRITE = 4;
	localparam int EV_READ = 5;
	localparam int EV_NUM = 6;
	localparam logic [11:0] EV_OFF [EV_NUM] = '{OFF_EV_STOPPED, OFF_EV_ERROR,
		OFF_EV_RX_BEGUN, OFF_EV_TX_BEGUN, OFF_EV_WRITE, OFF_EV_READ};

	// field positions
	localparam int ERR_RX_OVERFLOW = 0;
	localparam int ERR_TX_OVERREAD = 1;
	localparam int CFG_ADDR0_EN = 0;
	localparam int CFG_ADDR1_EN = 1;
	localparam int SHORT_READ_SUSPEND = 0;

	// reset values, and the enable value that turns the slave on
	localparam logic [3:0] ENABLE_ON = 4'h1;
	localparam logic [1:0] CONFIG_RESET = 2'h1;
	localparam logic [7:0] OVERREAD_RESET = 8'h00;
	localparam logic [6:0] ADDR_RESET = 7'h00;

	// bus bit values
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam logic BIT_ACK = 1'b0;
	localparam logic BIT_NACK = 1'b1;

	// data ram
	localparam int RAM_AW = 6;
	localparam int RAM_DEPTH = 64;

	// timing
	localparam int CLK_NS = 40;
	localparam int T_SETUP_NS = 250;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [8:0] {
		ST_IDLE = 9'b0_0000_0001,
		ST_ADDR = 9'b0_0000_0010,
		ST_ADDR_ACK = 9'b0_0000_0100,
		ST_WAIT = 9'b0_0000_1000,
		ST_TX_BYTE = 9'b0_0001_0000,
		ST_TX_ACK = 9'b0_0010_0000,
		ST_RX_BYTE = 9'b0_0100_0000,
		ST_RX_ACK = 9'b0_1000_0000,
		ST_DONE = 9'b1_0000_0000
	} tws_state_t;

endpackage

// *** src/tws_slave.sv ***
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
// How it works
// - a command is start, address, direction bit; one reads, zero writes
// - after the direction bit the slave drives ack low or leaves nack high
// - incoming address checked against two addresses, each enabled by config
// - ack a command only when the address matches an enabled address
// - acked read raises read event, acked write raises write event
// - new commands are seen from any state; enabling puts it in idle
// - prepare tasks set hidden transmit and receive prepared flags
// - after ack enter transmit or receive if prepared, else stretch the clock
// - entering transmit or receive raises begun event and clears its flag
// - transmit shifts out ram buffer bytes on the master's clock
// - repeated start during transmit or receive returns to address reception
// - bus stop outside idle and address reception raises halted event, clears prepared flag; any stop returns to idle
// - beyond transmit max count send overread character and raise error
// - receive stores up to max count; extra bytes nacked, dropped, error
// - pointer and count settings latched when the begun event fires
// - every accepted received byte within the limit is acked
// - transmitted and received byte tallies readable after each transaction
// - stop task forces halt, halted event, flag clear, bus release, idle
// - suspend task, or read shortcut, stretches the clock; resume continues
module tws_slave (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);
	import tws_pkg::*;

	function automatic logic [RAM_AW-1:0] ram_index(input logic [RAM_AW-1:0] base, input logic [7:0] cnt);
		ram_index = base + cnt[RAM_AW-1:0];
	endfunction

	logic [7:0] ram [RAM_DEPTH];

	// pin synchronisers
	logic [2:0] scl_sync, sda_sync;
	logic scl_f, sda_f, scl_d, sda_d;
	logic next_scl_f, next_sda_f;

	// apb and register state
	logic [EV_NUM-1:0] ev, next_ev, ev_set;
	logic short_rs, next_short_rs;
	logic [1:0] err_src, next_err_src, err_set;
	logic [3:0] enable, next_enable;
	logic [31:0] rx_ptr, next_rx_ptr, tx_ptr, next_tx_ptr;
	logic [7:0] rx_max, next_rx_max, tx_max, next_tx_max;
	logic [6:0] addr0, next_addr0, addr1, next_addr1;
	logic [1:0] cfg, next_cfg;
	logic [7:0] overread_character, next_orc;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic wr, t_stop, t_susp, t_resume, t_prep_rx, t_prep_tx;
	logic apb_ram_we;

	// link state
	tws_state_t state, next_state;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] shreg, next_shreg;
	logic [3:0] hold, next_hold;
	logic next_sda_oe_n, next_scl_oe_n;
	logic tx_prep, next_tx_prep, rx_prep, next_rx_prep;
	logic susp, next_susp, is_read, next_is_read, started, next_started;
	logic m_ack, next_m_ack, match, next_match;
	logic [RAM_AW-1:0] tx_base, next_tx_base, rx_base, next_rx_base;
	logic [7:0] tx_lim, next_tx_lim, rx_lim, next_rx_lim;
	logic [7:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
	logic link_we;
	logic [RAM_AW-1:0] link_waddr;
	logic scl_rise, scl_fall, bus_start, bus_stop, enabled, busy, ok, hit0, hit1;
	logic [7:0] cur_cnt, cur_lim, tx_byte;

	// a change counts once the second and third stages agree
	always_comb begin
		next_scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
		next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			scl_sync <= 3'b111;
			sda_sync <= 3'b111;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
			scl_f <= next_scl_f;
			sda_f <= next_sda_f;
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_d;
	assign scl_fall = ~scl_f & scl_d;
	assign bus_start = scl_f & scl_d & sda_d & ~sda_f;
	assign bus_stop = scl_f & scl_d & ~sda_d & sda_f;
	assign enabled = (enable == ENABLE_ON);
	assign busy = !(state inside {ST_IDLE, ST_ADDR});

	// apb slave: one setup, one access cycle; tasks act at the access edge
	always_comb begin
		wr = psel & penable & pready & pwrite & ~pslverr;
		t_stop = wr && paddr == OFF_TASK_STOP && pwdata[0];
		t_susp = wr && paddr == OFF_TASK_SUSPEND && pwdata[0];
		t_resume = wr && paddr == OFF_TASK_RESUME && pwdata[0];
		t_prep_rx = wr && paddr == OFF_TASK_PREP_RX && pwdata[0];
		t_prep_tx = wr && paddr == OFF_TASK_PREP_TX && pwdata[0];
		apb_ram_we = wr && paddr >= RAM_BASE && paddr < RAM_END;
		next_pready = psel & ~penable;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				OFF_TASK_STOP, OFF_TASK_SUSPEND, OFF_TASK_RESUME, OFF_TASK_PREP_RX, OFF_TASK_PREP_TX: ;
				OFF_EV_STOPPED: next_prdata[0] = ev[EV_STOPPED];
				OFF_EV_ERROR: next_prdata[0] = ev[EV_ERROR];
				OFF_EV_RX_BEGUN: next_prdata[0] = ev[EV_RX_BEGUN];
				OFF_EV_TX_BEGUN: next_prdata[0] = ev[EV_TX_BEGUN];
				OFF_EV_WRITE: next_prdata[0] = ev[EV_WRITE];
				OFF_EV_READ: next_prdata[0] = ev[EV_READ];
				OFF_SHORTS: next_prdata[0] = short_rs;
				OFF_ERR_SRC: next_prdata[1:0] = err_src;
				OFF_MATCH: next_prdata[0] = match;
				OFF_ENABLE: next_prdata[3:0] = enable;
				OFF_RX_PTR: next_prdata = rx_ptr;
				OFF_RX_MAX: next_prdata[7:0] = rx_max;
				OFF_RX_TALLY: next_prdata[7:0] = rx_cnt;
				OFF_TX_PTR: next_prdata = tx_ptr;
				OFF_TX_MAX: next_prdata[7:0] = tx_max;
				OFF_TX_TALLY: next_prdata[7:0] = tx_cnt;
				OFF_ADDR0: next_prdata[6:0] = addr0;
				OFF_ADDR1: next_prdata[6:0] = addr1;
				OFF_CONFIG: next_prdata[1:0] = cfg;
				OFF_OVERREAD: next_prdata[7:0] = overread_character;
				default: begin
					if (paddr >= RAM_BASE && paddr < RAM_END)
						next_prdata[7:0] = ram[paddr[RAM_AW+1:2]];
					else
						next_pslverr = 1'b1;
				end
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		for (int i = 0; i < EV_NUM; i++)
			next_ev[i] = ev_set[i] | ((wr && paddr == EV_OFF[i]) ? pwdata[0] : ev[i]);
		next_err_src = err_set | ((wr && paddr == OFF_ERR_SRC) ? (err_src & ~pwdata[1:0]) : err_src);
		next_short_rs = (wr && paddr == OFF_SHORTS) ? pwdata[SHORT_READ_SUSPEND] : short_rs;
		next_enable = (wr && paddr == OFF_ENABLE) ? pwdata[3:0] : enable;
		next_rx_ptr = (wr && paddr == OFF_RX_PTR) ? pwdata : rx_ptr;
		next_rx_max = (wr && paddr == OFF_RX_MAX) ? pwdata[7:0] : rx_max;
		next_tx_ptr = (wr && paddr == OFF_TX_PTR) ? pwdata : tx_ptr;
		next_tx_max = (wr && paddr == OFF_TX_MAX) ? pwdata[7:0] : tx_max;
		next_addr0 = (wr && paddr == OFF_ADDR0) ? pwdata[6:0] : addr0;
		next_addr1 = (wr && paddr == OFF_ADDR1) ? pwdata[6:0] : addr1;
		next_cfg = (wr && paddr == OFF_CONFIG) ? pwdata[1:0] : cfg;
		next_orc = (wr && paddr == OFF_OVERREAD) ? pwdata[7:0] : overread_character;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ev <= '0;
			err_src <= 2'h0;
			short_rs <= 1'b0;
			enable <= 4'h0;
			rx_ptr <= 32'h0000_0000;
			rx_max <= 8'h00;
			tx_ptr <= 32'h0000_0000;
			tx_max <= 8'h00;
			addr0 <= ADDR_RESET;
			addr1 <= ADDR_RESET;
			cfg <= CONFIG_RESET;
			overread_character <= OVERREAD_RESET;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			ev <= next_ev;
			err_src <= next_err_src;
			short_rs <= next_short_rs;
			enable <= next_enable;
			rx_ptr <= next_rx_ptr;
			rx_max <= next_rx_max;
			tx_ptr <= next_tx_ptr;
			tx_max <= next_tx_max;
			addr0 <= next_addr0;
			addr1 <= next_addr1;
			cfg <= next_cfg;
			overread_character <= next_orc;
		end
	end

	// link writes win over software; the two rarely meet while a receive runs
	always_ff @(posedge mclk) begin
		if (link_we)
			ram[link_waddr] <= shreg;
		else if (apb_ram_we)
			ram[paddr[RAM_AW+1:2]] <= pwdata[7:0];
	end

	// bus engine
	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_hold = (hold != 4'h0) ? hold - 4'h1 : hold;
		next_sda_oe_n = sda_oe_n;
		next_tx_prep = tx_prep;
		next_rx_prep = rx_prep;
		next_susp = susp;
		next_is_read = is_read;
		next_started = started;
		next_m_ack = m_ack;
		next_match = match;
		next_tx_base = tx_base;
		next_rx_base = rx_base;
		next_tx_lim = tx_lim;
		next_rx_lim = rx_lim;
		next_tx_cnt = tx_cnt;
		next_rx_cnt = rx_cnt;
		ev_set = '0;
		err_set = 2'h0;
		link_we = 1'b0;
		link_waddr = ram_index(rx_base, rx_cnt);
		hit0 = cfg[CFG_ADDR0_EN] && shreg[7:1] == addr0;
		hit1 = cfg[CFG_ADDR1_EN] && shreg[7:1] == addr1;
		ok = !susp && (started || (is_read ? tx_prep : rx_prep));
		cur_cnt = started ? tx_cnt : 8'h00;
		cur_lim = started ? tx_lim : tx_max;
		tx_byte = (cur_cnt < cur_lim) ? ram[ram_index(started ? tx_base : tx_ptr[RAM_AW-1:0], cur_cnt)] : overread_character;
		if (!enabled) begin
			next_state = ST_IDLE;
			next_sda_oe_n = 1'b1;
			next_hold = 4'h0;
		end else if (t_stop) begin
			ev_set[EV_STOPPED] = 1'b1;
			if (is_read)
				next_tx_prep = 1'b0;
			else
				next_rx_prep = 1'b0;
			next_state = ST_IDLE;
			next_sda_oe_n = 1'b1;
			next_hold = 4'h0;
			next_susp = 1'b0;
		end else if (bus_start) begin
			// a restart drops any transfer and goes straight back to receiving an address
			next_state = ST_ADDR;
			next_bitcnt = 4'h0;
			next_sda_oe_n = 1'b1;
		end else if (bus_stop) begin
			if (busy) begin
				ev_set[EV_STOPPED] = 1'b1;
				if (is_read)
					next_tx_prep = 1'b0;
				else
					next_rx_prep = 1'b0;
			end
			next_state = ST_IDLE;
			next_sda_oe_n = 1'b1;
			next_hold = 4'h0;
		end else begin
			case (state)
				ST_IDLE, ST_DONE: ;
				ST_ADDR: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_f};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
						if (hit0 || hit1) begin
							next_sda_oe_n = BIT_ACK;
							next_match = !hit0;
							next_is_read = (shreg[0] == DIR_READ);
							next_started = 1'b0;
							next_state = ST_ADDR_ACK;
							next_hold = 4'(SETUP_CYC);
							if (shreg[0] == DIR_READ) begin
								ev_set[EV_READ] = 1'b1;
								if (short_rs)
									next_susp = 1'b1;
							end else begin
								ev_set[EV_WRITE] = 1'b1;
							end
						end else begin
							next_state = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						next_sda_oe_n = 1'b1;
						next_state = ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (ok) begin
						next_started = 1'b1;
						next_bitcnt = 4'h0;
						next_hold = 4'(SETUP_CYC);
						if (is_read) begin
							if (!started) begin
								ev_set[EV_TX_BEGUN] = 1'b1;
								next_tx_prep = 1'b0;
								next_tx_base = tx_ptr[RAM_AW-1:0];
								next_tx_lim = tx_max;
							end
							if (cur_cnt < cur_lim) begin
								next_tx_cnt = cur_cnt + 8'h01;
							end else begin
								next_tx_cnt = cur_cnt;
								ev_set[EV_ERROR] = 1'b1;
								err_set[ERR_TX_OVERREAD] = 1'b1;
							end
							next_shreg = tx_byte;
							next_sda_oe_n = tx_byte[7];
							next_state = ST_TX_BYTE;
						end else begin
							if (!started) begin
								ev_set[EV_RX_BEGUN] = 1'b1;
								next_rx_prep = 1'b0;
								next_rx_base = rx_ptr[RAM_AW-1:0];
								next_rx_lim = rx_max;
								next_rx_cnt = 8'h00;
							end
							next_state = ST_RX_BYTE;
						end
					end
				end
				ST_TX_BYTE: begin
					if (scl_rise) begin
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall) begin
						next_hold = 4'(SETUP_CYC);
						if (bitcnt == BITS_PER_BYTE) begin
							next_sda_oe_n = 1'b1;
							next_state = ST_TX_ACK;
						end else begin
							next_shreg = {shreg[6:0], 1'b0};
							next_sda_oe_n = shreg[6];
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise)
						next_m_ack = (sda_f == BIT_ACK);
					else if (scl_fall)
						next_state = m_ack ? ST_WAIT : ST_DONE;
				end
				ST_RX_BYTE: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_f};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
						next_hold = 4'(SETUP_CYC);
						next_state = ST_RX_ACK;
						if (rx_cnt < rx_lim) begin
							link_we = 1'b1;
							next_rx_cnt = rx_cnt + 8'h01;
							next_sda_oe_n = BIT_ACK;
						end else begin
							next_sda_oe_n = BIT_NACK;
							ev_set[EV_ERROR] = 1'b1;
							err_set[ERR_RX_OVERFLOW] = 1'b1;
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						next_sda_oe_n = 1'b1;
						next_state = ST_WAIT;
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end
		if (t_prep_tx)
			next_tx_prep = 1'b1;
		if (t_prep_rx)
			next_rx_prep = 1'b1;
		if (t_susp)
			next_susp = 1'b1;
		else if (t_resume && !(ev_set[EV_READ] && short_rs))
			next_susp = 1'b0;
		// a shortcut suspend raised in the same cycle outlasts the resume
		// scl held low while data settles and while waiting for software
		next_scl_oe_n = !(next_hold != 4'h0 || next_state == ST_WAIT);
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			hold <= 4'h0;
			sda_oe_n <= 1'b1;
			scl_oe_n <= 1'b1;
			sda_out <= 1'b0;
			scl_out <= 1'b0;
			tx_prep <= 1'b0;
			rx_prep <= 1'b0;
			susp <= 1'b0;
			is_read <= 1'b0;
			started <= 1'b0;
			m_ack <= 1'b0;
			match <= 1'b0;
			tx_base <= '0;
			rx_base <= '0;
			tx_lim <= 8'h00;
			rx_lim <= 8'h00;
			tx_cnt <= 8'h00;
			rx_cnt <= 8'h00;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			hold <= next_hold;
			sda_oe_n <= next_sda_oe_n;
			scl_oe_n <= next_scl_oe_n;
			sda_out <= 1'b0;
			scl_out <= 1'b0;
			tx_prep <= next_tx_prep;
			rx_prep <= next_rx_prep;
			susp <= next_susp;
			is_read <= next_is_read;
			started <= next_started;
			m_ack <= next_m_ack;
			match <= next_match;
			tx_base <= next_tx_base;
			rx_base <= next_rx_base;
			tx_lim <= next_tx_lim;
			rx_lim <= next_rx_lim;
			tx_cnt <= next_tx_cnt;
			rx_cnt <= next_rx_cnt;
		end
	end

endmodule

// *** testbench/tws_chk.sv ***
`timescale 1ns/1ns
module tws_chk (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_out,
	input wire logic sda_oe_n
);
	import tws_pkg::*;
	logic en_q;
	// shadow of the enable field; pins must stay released while it is off
	always_ff @(posedge mclk) begin
		if (!resetn)
			en_q <= 1'h0;
		else if (psel && penable && pready && pwrite && paddr == OFF_ENABLE)
			en_q <= pwdata[3:0] == ENABLE_ON;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence stop_s;
		psel && penable && pready && pwrite && paddr == OFF_TASK_STOP && pwdata[0];
	endsequence
	ready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
		else $error("pready is not a one cycle answer");
	err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused access returned data");
	drive_low_a: assert property (!scl_out && !sda_out)
		else $error("open drain output drove high");
	// a data change under a high clock would look like a start or stop
	sda_move_a: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data line moved while clock high");
	stop_release_a: assert property (stop_s |-> ##[1:8] scl_oe_n && sda_oe_n)
		else $error("stop task left the bus held");
	reset_quiet_a: assert property (disable iff (1'h0) !resetn |=> scl_oe_n && sda_oe_n && !pready)
		else $error("outputs active in reset");
	off_quiet_a: assert property (!en_q [*2] |-> scl_oe_n && sda_oe_n)
		else $error("disabled slave holds a line");
	stretch_min_a: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*5])
		else $error("clock stretch too short");
endmodule
bind tws_slave tws_chk tws_chk_inst (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .scl_in, .scl_out, .scl_oe_n, .sda_out, .sda_oe_n);

// *** testbench/tws_m.sv ***
`timescale 1ns/1ns
module tws_m (
	input wire logic mclk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_n,
	output logic sda_n
);
	initial begin
		scl_n = 1'h1;
		sda_n = 1'h1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// the slave may stretch, so the high phase starts only once the wire is high
	task automatic hi();
		scl_n <= 1'h1;
		do @(negedge mclk); while (!scl);
		@(posedge mclk);
	endtask
	// low for five cycles: the slave sees a fall four cycles late and may only then start its stretch
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_n <= b;
		tick(4);
		hi();
		tick(1);
		@(negedge mclk) r = sda;
		@(posedge mclk) scl_n <= 1'h0;
	endtask
	task automatic start();
		tick(1);
		if (!scl_n) begin
			sda_n <= 1'h1;
			tick(4);
			hi();
			tick(3);
		end
		sda_n <= 1'h0;
		tick(4);
		scl_n <= 1'h0;
	endtask
	task automatic stop();
		tick(1);
		sda_n <= 1'h0;
		tick(4);
		hi();
		tick(3);
		sda_n <= 1'h1;
		tick(4);
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'h1, ack);
	endtask
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'h1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// *** testbench/test_tws_slave.sv ***
`timescale 1ns/1ns
module test_tws_slave;
	import tws_pkg::*;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, se, ack;
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_n, sda_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] b;
	wire logic scl = scl_n & scl_oe_n;
	wire logic sda = sda_n & sda_oe_n;
	int err_total = 0;
	int checks_done = 0;
	tws_slave tws_slave_inst (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda), .sda_out, .sda_oe_n);
	tws_m tws_m_inst (.mclk, .scl, .sda, .scl_n, .sda_n);
	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask
	task automatic ev(input logic [5:0] m);
		for (int i = 0; i < EV_NUM; i++) begin
			rdc("event", EV_OFF[i], {31'h0000_0000, m[i]});
			wr(EV_OFF[i], 32'h0000_0000);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// whole run is a few thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		wrap_up();
	end
	initial begin
		resetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge mclk);
		resetn <= 1'h1;
		rdc("config", OFF_CONFIG, 32'(CONFIG_RESET));
		rdc("unmapped", 12'h700, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, 32'(se));
		wr(OFF_ADDR0, 32'h0000_002A);
		wr(OFF_ADDR1, 32'h0000_0035);
		wr(OFF_CONFIG, 32'h0000_0003);
		wr(OFF_OVERREAD, 32'h0000_00A5);
		wr(OFF_RX_PTR, 32'h0000_0000);
		wr(OFF_RX_MAX, 32'h0000_0003);
		wr(OFF_TX_PTR, 32'h0000_0008);
		wr(OFF_TX_MAX, 32'h0000_0002);
		wr(RAM_BASE + 12'h020, 32'h0000_005C);
		wr(RAM_BASE + 12'h024, 32'h0000_003E);
		wr(OFF_ENABLE, 32'(ENABLE_ON));
		fork
			begin
				tws_m_inst.start();
				tws_m_inst.put({7'h2A, DIR_WRITE}, ack);
				chk("addr ack", 32'(BIT_ACK), 32'(ack));
				for (int i = 0; i < 4; i++) begin
					tws_m_inst.put(8'h61 + 8'(i), ack);
					chk("rx ack", 32'(i < 3 ? BIT_ACK : BIT_NACK), 32'(ack));
				end
				tws_m_inst.stop();
			end
			begin
				repeat (150) @(posedge mclk);
				chk("stretch", 32'h0000_0000, 32'(scl));
				wr(OFF_TASK_PREP_RX, 32'h0000_0001);
			end
		join
		ev(6'h17);
		rdc("err src", OFF_ERR_SRC, 32'h0000_0001);
		rdc("rx tally", OFF_RX_TALLY, 32'h0000_0003);
		for (int i = 0; i < 3; i++)
			rdc("rx ram", RAM_BASE + 12'(4 * i), 32'h0000_0061 + 32'(i));
		rdc("match", OFF_MATCH, 32'h0000_0000);
		wr(OFF_ERR_SRC, 32'h0000_0003);
		$display("write test done");
		wr(OFF_TASK_PREP_TX, 32'h0000_0001);
		fork
			begin
				tws_m_inst.start();
				tws_m_inst.put({7'h35, DIR_READ}, ack);
				chk("addr ack", 32'(BIT_ACK), 32'(ack));
				for (int i = 0; i < 3; i++) begin
					tws_m_inst.get(i == 2, b);
					chk("tx byte", 32'(i == 0 ? 8'h5C : i == 1 ? 8'h3E : 8'hA5), 32'(b));
				end
				tws_m_inst.stop();
			end
			begin
				repeat (160) @(posedge mclk);
				wr(OFF_TX_PTR, 32'h0000_0030);
			end
		join
		ev(6'h2B);
		rdc("err src", OFF_ERR_SRC, 32'h0000_0002);
		rdc("tx tally", OFF_TX_TALLY, 32'h0000_0002);
		rdc("match", OFF_MATCH, 32'h0000_0001);
		wr(OFF_ERR_SRC, 32'h0000_0003);
		wr(OFF_TX_PTR, 32'h0000_0008);
		$display("read test done");
		wr(OFF_ENABLE, 32'h0000_0000);
		wr(OFF_CONFIG, 32'h0000_0001);
		wr(OFF_ENABLE, 32'(ENABLE_ON));
		tws_m_inst.start();
		tws_m_inst.put({7'h35, DIR_READ}, ack);
		chk("nack", 32'(BIT_NACK), 32'(ack));
		rdc("no read", OFF_EV_READ, 32'h0000_0000);
		$display("no match test done");
		wr(OFF_SHORTS, 32'h0000_0001);
		wr(OFF_TASK_PREP_RX, 32'h0000_0001);
		wr(OFF_TASK_PREP_TX, 32'h0000_0001);
		fork
			begin
				tws_m_inst.start();
				tws_m_inst.put({7'h2A, DIR_WRITE}, ack);
				tws_m_inst.put(8'h77, ack);
				tws_m_inst.start();
				tws_m_inst.put({7'h2A, DIR_READ}, ack);
				chk("addr ack", 32'(BIT_ACK), 32'(ack));
				tws_m_inst.get(1'h1, b);
				chk("tx byte", 32'h0000_005C, 32'(b));
				tws_m_inst.stop();
			end
			begin
				do apb(1'h0, OFF_EV_READ, 32'h0000_0000); while (rd[0] !== 1'h1);
				repeat (40) @(posedge mclk);
				chk("suspend", 32'h0000_0000, 32'(scl));
				wr(OFF_TASK_RESUME, 32'h0000_0001);
			end
		join
		ev(6'h3D);
		wr(OFF_SHORTS, 32'h0000_0000);
		$display("restart test done");
		fork
			begin
				tws_m_inst.start();
				tws_m_inst.put({7'h2A, DIR_WRITE}, ack);
				tws_m_inst.stop();
			end
			begin
				repeat (150) @(posedge mclk);
				chk("stretch", 32'h0000_0000, 32'(scl));
				wr(OFF_TASK_STOP, 32'h0000_0001);
			end
		join
		ev(6'h11);
		wr(OFF_ENABLE, 32'h0000_0000);
		$display("stop task test done");
		wrap_up();
	end
endmodule
